// ==== common/mat_pkg.sv ====
package mat_pkg;

  // Buffer geometry.
  localparam int unsigned MAT_WAYS   = 4;
  localparam int unsigned MAT_SETS   = 32;
  localparam int unsigned MAT_IDX_W  = 5;
  localparam int unsigned MAT_VPN_W  = 22;
  localparam int unsigned MAT_PPN_W  = 19;
  localparam int unsigned MAT_PROCESS_IDENTIFIER_W = 8;

  // Register byte addresses.
  localparam logic [31:0] MAT_CTRL_ADDR  = 32'h0fffffe0;
  localparam logic [31:0] MAT_LOAD_ADDR  = 32'h0fffffe4;
  localparam logic [31:0] MAT_PEH_ADDR   = 32'h0ffffff0;
  localparam logic [31:0] MAT_PEL_ADDR   = 32'hfffffff4;
  localparam logic [31:0] MAT_TBASE_ADDR = 32'h0ffffff8;
  localparam logic [31:0] MAT_FAULT_ADDR = 32'h0ffffffc;

  // Reset values.
  localparam logic [31:0] MAT_CTRL_RST  = 32'h00000000;
  localparam logic [31:0] MAT_PEH_RST   = 32'h00000000;
  localparam logic [31:0] MAT_PEL_RST   = 32'h00000000;
  localparam logic [31:0] MAT_TBASE_RST = 32'h00000000;
  localparam logic [31:0] MAT_FAULT_RST = 32'h00000000;

  // mmu_control fields; the flush bit is a write-only trigger.
  localparam int unsigned MAT_CTL_EN_BIT    = 0;
  localparam int unsigned MAT_CTL_FLUSH_BIT = 2;
  localparam int unsigned MAT_CTL_SV_BIT    = 8;
  localparam int unsigned MAT_CTL_IX_BIT    = 9;
  localparam logic [31:0] MAT_CTL_MASK      = 32'h00000301;

  // page_entry_high fields.
  localparam int unsigned MAT_PEH_VPN_LSB = 10;

  // page_entry_low fields.
  localparam int unsigned MAT_PEL_PPN_LSB = 10;
  localparam int unsigned MAT_PEL_V_BIT   = 8;
  localparam int unsigned MAT_PEL_PR_LSB  = 5;
  localparam int unsigned MAT_PEL_SZ_BIT  = 4;
  localparam int unsigned MAT_PEL_C_BIT   = 3;
  localparam int unsigned MAT_PEL_D_BIT   = 2;
  localparam int unsigned MAT_PEL_SH_BIT  = 1;
  localparam logic [31:0] MAT_PEL_MASK    = 32'h1ffffd7e;

  // Region decode on the top logical address bits.
  localparam logic [2:0] MAT_TOP_P1 = 3'h4;
  localparam logic [2:0] MAT_TOP_P2 = 3'h5;
  localparam logic [2:0] MAT_TOP_P3 = 3'h6;
  localparam logic [2:0] MAT_TOP_P4 = 3'h7;
  localparam logic [7:0] MAT_XY_TOP = 8'ha5;

  // Page protection codes.
  localparam logic [1:0] MAT_PR_PRIV_RO = 2'h0;
  localparam logic [1:0] MAT_PR_PRIV_RW = 2'h1;
  localparam logic [1:0] MAT_PR_ALL_RO  = 2'h2;
  localparam logic [1:0] MAT_PR_ALL_RW  = 2'h3;

  typedef enum logic [2:0] {
    MAT_EXC_NONE       = 3'h0,
    MAT_EXC_MISS       = 3'h1,
    MAT_EXC_ADDR_ERR   = 3'h2,
    MAT_EXC_PROT       = 3'h3,
    MAT_EXC_INIT_WRITE = 3'h4
  } mat_exc_t;

endpackage

// ==== hdl/mat_way.sv ====
`timescale 1ns/1ps
module mat_way (
  // Clock and reset.
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // Entry load and flush.
  input  wire logic                            flush,
  input  wire logic                            wr_en,
  input  wire logic [mat_pkg::MAT_IDX_W-1:0]   wr_idx,
  input  wire logic [mat_pkg::MAT_VPN_W-1:0]   wr_vpn,
  input  wire logic [mat_pkg::MAT_PROCESS_IDENTIFIER_W-1:0]  wr_process_identifier,
  input  wire logic [mat_pkg::MAT_PPN_W-1:0]   wr_ppn,
  input  wire logic                            wr_valid,
  input  wire logic                            wr_sz,
  input  wire logic                            wr_sh,
  input  wire logic                            wr_c,
  input  wire logic                            wr_d,
  input  wire logic [1:0]                      wr_pr,
  // Lookup.
  input  wire logic [mat_pkg::MAT_IDX_W-1:0]   rd_idx,
  input  wire logic [mat_pkg::MAT_VPN_W-1:0]   cmp_vpn,
  input  wire logic [mat_pkg::MAT_PROCESS_IDENTIFIER_W-1:0]  cmp_process_identifier,
  input  wire logic                            skip_process_identifier,
  // Lookup result.
  output logic                                 hit,
  output logic [mat_pkg::MAT_PPN_W-1:0]        ppn,
  output logic                                 sz,
  output logic                                 c,
  output logic                                 d,
  output logic [1:0]                           pr
);
  import mat_pkg::*;

  logic [MAT_VPN_W-1:0]  vpn_mem  [MAT_SETS];
  logic [MAT_PROCESS_IDENTIFIER_W-1:0] process_identifier_mem [MAT_SETS];
  logic [MAT_PPN_W-1:0]  ppn_mem  [MAT_SETS];
  logic [5:0]            flag_mem [MAT_SETS];
  logic [MAT_SETS-1:0]   valid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= '0;
    end else if (flush) begin
      valid_q <= '0;
    end else if (wr_en) begin
      valid_q[wr_idx] <= wr_valid;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      vpn_mem[wr_idx]  <= wr_vpn;
      process_identifier_mem[wr_idx] <= wr_process_identifier;
      ppn_mem[wr_idx]  <= wr_ppn;
      flag_mem[wr_idx] <= {wr_sz, wr_sh, wr_c, wr_d, wr_pr};
    end
  end

  wire logic [MAT_VPN_W-1:0] ent_vpn   = vpn_mem[rd_idx];
  wire logic [5:0]           ent_flags = flag_mem[rd_idx];
  wire logic                 ent_sz    = ent_flags[5];
  wire logic                 ent_sh    = ent_flags[4];
  // Bits 11..10 of the page number matter only on small pages.
  wire logic vpn_match  = (ent_vpn[MAT_VPN_W-1:2] == cmp_vpn[MAT_VPN_W-1:2]) &&
                          (ent_sz || (ent_vpn[1:0] == cmp_vpn[1:0]));
  wire logic process_identifier_match = skip_process_identifier || ent_sh || (process_identifier_mem[rd_idx] == cmp_process_identifier);

  assign hit = valid_q[rd_idx] && vpn_match && process_identifier_match;
  assign ppn = ppn_mem[rd_idx];
  assign sz  = ent_sz;
  assign c   = ent_flags[3];
  assign d   = ent_flags[2];
  assign pr  = ent_flags[1:0];

endmodule

// ==== hdl/mat_top.sv ====
// Function
// - Privileged low, high mapped regions translate per page.
// - Cached fixed region clears bit 31, cacheable.
// - Uncached fixed region clears bits 31..29, never cached.
// - Fixed regions bypass buffer, raise no translation exception.
// - Top privileged region routes to on-chip registers.
// - User mode maps addresses below 0x80000000 per page.
// - User, extension off, upper half gives address error.
// - Extension on admits uncached fixed window 0xa5xxxxxx.
// - Extension on, other upper addresses give address error.
// - Buffer hit yields physical address and page control.
// - No match raises miss; core re-executes instruction.
// - Translation off passes address, top three bits dropped.
// - Cache tag address has top three bits zero.
// - Control bit picks single or multiple space compare.
// - Eight-bit identifier in page_entry_high, no flush needed.
// - Page sizes of 1 kbyte and 4 kbytes.
// - Per-page access rights for privileged and user mode.
// - The presetn reset reinitialises all five registers.
// - Control register resets to zero, mode bit included.
// - Four ways, 128 entries, searched in parallel.
// - Index hash xors page bits 16..12 with identifier.
// - Bits 11..10 compared only on small pages.
// - Identifier compare skipped in single space privileged mode.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module mat_top (
  // Clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB register port.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Core access request.
  input  wire logic                   acc_valid,
  input  wire logic [31:0]            acc_addr,
  input  wire logic                   acc_write,
  input  wire logic                   privileged_mode_flag,
  input  wire logic                   signal_proc_extension_flag,
  // Core access answer.
  output logic                        rsp_valid,
  output logic [31:0]                 rsp_paddr,
  output logic [31:0]                 rsp_cache_tag,
  output logic                        rsp_cacheable,
  output logic                        rsp_onchip,
  output mat_pkg::mat_exc_t           rsp_exc,
  output logic [31:0]                 rsp_fault_addr
);
  import mat_pkg::*;

  // Registers.
  logic [31:0] mmu_control_q;
  logic [31:0] page_entry_high_q;
  logic [31:0] page_entry_low_q;
  logic [31:0] table_base_q;
  logic [31:0] fault_address_q;

  // APB outputs.
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // Answer outputs.
  logic        rsp_valid_q;
  logic [31:0] rsp_paddr_q;
  logic [31:0] rsp_cache_tag_q;
  logic        rsp_cacheable_q;
  logic        rsp_onchip_q;
  mat_exc_t    rsp_exc_q;
  logic [31:0] rsp_fault_addr_q;

  function automatic logic [31:0] mat_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // APB decode.
  wire logic setup_ph  = psel && !penable && !pready_q;
  wire logic access_ok = psel && penable && pready_q;
  wire logic hit_ctrl  = (paddr == MAT_CTRL_ADDR);
  wire logic hit_load  = (paddr == MAT_LOAD_ADDR);
  wire logic hit_peh   = (paddr == MAT_PEH_ADDR);
  wire logic hit_pel   = (paddr == MAT_PEL_ADDR);
  wire logic hit_tbase = (paddr == MAT_TBASE_ADDR);
  wire logic hit_fault = (paddr == MAT_FAULT_ADDR);
  wire logic mapped    = hit_ctrl || hit_load || hit_peh || hit_pel || hit_tbase || hit_fault;
  wire logic wr_ok     = access_ok && pwrite && mapped;
  wire logic wr_ctrl   = wr_ok && hit_ctrl;
  wire logic wr_load   = wr_ok && hit_load;
  wire logic wr_peh    = wr_ok && hit_peh;
  wire logic wr_pel    = wr_ok && hit_pel;
  wire logic wr_tbase  = wr_ok && hit_tbase;
  wire logic wr_fault  = wr_ok && hit_fault;

  wire logic [31:0] rd_mux = hit_ctrl  ? (mmu_control_q & MAT_CTL_MASK) :
                             hit_peh   ? page_entry_high_q :
                             hit_pel   ? page_entry_low_q :
                             hit_tbase ? table_base_q :
                             hit_fault ? fault_address_q : 32'h00000000;

  wire logic [31:0] ctrl_wval = mat_merge(mmu_control_q, pwdata, pstrb);
  wire logic [31:0] peh_wval  = mat_merge(page_entry_high_q, pwdata, pstrb);
  wire logic        flush     = wr_ctrl && pstrb[0] && pwdata[MAT_CTL_FLUSH_BIT];

  // Control fields.
  wire logic mmu_on            = mmu_control_q[MAT_CTL_EN_BIT];
  wire logic single_space_mode = mmu_control_q[MAT_CTL_SV_BIT];
  wire logic index_hash_select = mmu_control_q[MAT_CTL_IX_BIT];
  wire logic [MAT_PROCESS_IDENTIFIER_W-1:0] process_identifier = page_entry_high_q[MAT_PROCESS_IDENTIFIER_W-1:0];

  // Entry load from the page entry registers.
  wire logic [MAT_VPN_W-1:0] peh_vpn = page_entry_high_q[31:MAT_PEH_VPN_LSB];
  wire logic [MAT_IDX_W-1:0] id_hash = index_hash_select ? process_identifier[MAT_IDX_W-1:0] : 5'h00;
  wire logic [MAT_IDX_W-1:0] load_idx = peh_vpn[6:2] ^ id_hash;
  wire logic [1:0]           load_way = pwdata[1:0];

  // Region decode of the access address.
  wire logic [2:0] top3       = acc_addr[31:29];
  wire logic [MAT_VPN_W-1:0] acc_vpn = acc_addr[31:10];
  wire logic lower_half       = !acc_addr[31];
  wire logic in_p1            = (top3 == MAT_TOP_P1);
  wire logic in_p2            = (top3 == MAT_TOP_P2);
  wire logic in_p3            = (top3 == MAT_TOP_P3);
  wire logic in_p4            = (top3 == MAT_TOP_P4);
  wire logic in_xy            = (acc_addr[31:24] == MAT_XY_TOP);
  wire logic priv             = privileged_mode_flag;
  wire logic user_xy          = !priv && signal_proc_extension_flag && in_xy;
  wire logic user_bad         = !priv && !lower_half && !user_xy;
  wire logic paged_region     = priv ? (lower_half || in_p3) : lower_half;
  wire logic translate        = paged_region && mmu_on;

  // Buffer search.
  wire logic [MAT_IDX_W-1:0] acc_idx = acc_vpn[6:2] ^ id_hash;
  wire logic skip_process_identifier = single_space_mode && priv;

  logic [MAT_WAYS-1:0] way_hit;
  logic [MAT_PPN_W-1:0] way_ppn [MAT_WAYS];
  logic [MAT_WAYS-1:0] way_sz;
  logic [MAT_WAYS-1:0] way_c;
  logic [MAT_WAYS-1:0] way_d;
  logic [1:0]          way_pr [MAT_WAYS];

  for (genvar w = 0; w < MAT_WAYS; w++) begin : g_way
    // All ways are looked up in the same cycle.
    mat_way u_way (
      .pclk      (pclk),
      .presetn   (presetn),
      .flush     (flush),
      .wr_en     (wr_load && (load_way == 2'(w))),
      .wr_idx    (load_idx),
      .wr_vpn    (peh_vpn),
      .wr_process_identifier   (process_identifier),
      .wr_ppn    (page_entry_low_q[28:MAT_PEL_PPN_LSB]),
      .wr_valid  (page_entry_low_q[MAT_PEL_V_BIT]),
      .wr_sz     (page_entry_low_q[MAT_PEL_SZ_BIT]),
      .wr_sh     (page_entry_low_q[MAT_PEL_SH_BIT]),
      .wr_c      (page_entry_low_q[MAT_PEL_C_BIT]),
      .wr_d      (page_entry_low_q[MAT_PEL_D_BIT]),
      .wr_pr     (page_entry_low_q[MAT_PEL_PR_LSB +: 2]),
      .rd_idx    (acc_idx),
      .cmp_vpn   (acc_vpn),
      .cmp_process_identifier  (process_identifier),
      .skip_process_identifier (skip_process_identifier),
      .hit       (way_hit[w]),
      .ppn       (way_ppn[w]),
      .sz        (way_sz[w]),
      .c         (way_c[w]),
      .d         (way_d[w]),
      .pr        (way_pr[w])
    );
  end

  // Select the hitting way; software keeps hits unique.
  logic [MAT_PPN_W-1:0] sel_ppn;
  logic                 sel_sz;
  logic                 sel_c;
  logic                 sel_d;
  logic [1:0]           sel_pr;
  always_comb begin
    sel_ppn = '0;
    sel_sz  = 1'b0;
    sel_c   = 1'b0;
    sel_d   = 1'b0;
    sel_pr  = 2'h0;
    for (int w = 0; w < MAT_WAYS; w++) begin
      if (way_hit[w]) begin
        sel_ppn = way_ppn[w];
        sel_sz  = way_sz[w];
        sel_c   = way_c[w];
        sel_d   = way_d[w];
        sel_pr  = way_pr[w];
      end
    end
  end

  wire logic tlb_hit = |way_hit;
  // Large pages keep twelve offset bits, small pages ten.
  wire logic [31:0] xlat_paddr = sel_sz ? {3'h0, sel_ppn[MAT_PPN_W-1:2], acc_addr[11:0]} :
                                          {3'h0, sel_ppn, acc_addr[9:0]};
  wire logic prot_fail = priv ? (acc_write && !sel_pr[0]) :
                                ((sel_pr == MAT_PR_PRIV_RO) || (sel_pr == MAT_PR_PRIV_RW) ||
                                 (acc_write && (sel_pr == MAT_PR_ALL_RO)));
  wire logic init_write = acc_write && !sel_d;

  // Per-access answer.
  logic [31:0] nx_paddr;
  logic        nx_cache;
  logic        nx_onchip;
  mat_exc_t    nx_exc;
  always_comb begin
    nx_paddr  = {3'h0, acc_addr[28:0]};
    nx_cache  = 1'b0;
    nx_onchip = 1'b0;
    nx_exc    = MAT_EXC_NONE;
    if (user_bad) begin
      nx_exc = MAT_EXC_ADDR_ERR;
    end else if (user_xy) begin
      nx_paddr = acc_addr;
    end else if (priv && in_p4) begin
      nx_paddr  = acc_addr;
      nx_onchip = 1'b1;
    end else if (priv && in_p1) begin
      nx_paddr = {1'b0, acc_addr[30:0]};
      nx_cache = 1'b1;
    end else if (priv && in_p2) begin
      nx_paddr = {3'h0, acc_addr[28:0]};
    end else if (translate) begin
      if (!tlb_hit) begin
        nx_exc = MAT_EXC_MISS;
      end else if (prot_fail) begin
        nx_exc = MAT_EXC_PROT;
      end else if (init_write) begin
        nx_exc = MAT_EXC_INIT_WRITE;
      end else begin
        nx_paddr = xlat_paddr;
        nx_cache = sel_c;
      end
    end else begin
      nx_cache = 1'b1;
    end
  end

  wire logic acc_fault = acc_valid && (nx_exc != MAT_EXC_NONE);

  // Register file; a fault capture beats a same-cycle software write, except the identifier field of page_entry_high, which takes the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mmu_control_q     <= MAT_CTRL_RST;
      page_entry_high_q <= MAT_PEH_RST;
      page_entry_low_q  <= MAT_PEL_RST;
      table_base_q      <= MAT_TBASE_RST;
      fault_address_q   <= MAT_FAULT_RST;
    end else begin
      if (wr_ctrl) begin
        mmu_control_q <= ctrl_wval & MAT_CTL_MASK;
      end
      if (acc_fault) begin
        page_entry_high_q[31:MAT_PEH_VPN_LSB] <= acc_vpn;
        if (wr_peh) begin
          page_entry_high_q[MAT_PROCESS_IDENTIFIER_W-1:0] <= peh_wval[MAT_PROCESS_IDENTIFIER_W-1:0];
        end
      end else if (wr_peh) begin
        page_entry_high_q <= peh_wval;
      end
      if (wr_pel) begin
        page_entry_low_q <= mat_merge(page_entry_low_q, pwdata, pstrb) & MAT_PEL_MASK;
      end
      if (wr_tbase) begin
        table_base_q <= mat_merge(table_base_q, pwdata, pstrb);
      end
      if (acc_fault) begin
        fault_address_q <= acc_addr;
      end else if (wr_fault) begin
        fault_address_q <= mat_merge(fault_address_q, pwdata, pstrb);
      end
    end
  end

  // APB answer: no wait state, ready in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= !mapped;
      end else if (access_ok) begin
        prdata_q  <= 32'h00000000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Core answer, one cycle after the request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q      <= 1'b0;
      rsp_paddr_q      <= 32'h00000000;
      rsp_cache_tag_q  <= 32'h00000000;
      rsp_cacheable_q  <= 1'b0;
      rsp_onchip_q     <= 1'b0;
      rsp_exc_q        <= MAT_EXC_NONE;
      rsp_fault_addr_q <= 32'h00000000;
    end else begin
      rsp_valid_q <= acc_valid;
      if (acc_valid) begin
        rsp_paddr_q      <= nx_paddr;
        rsp_cache_tag_q  <= {3'h0, nx_paddr[28:0]};
        rsp_cacheable_q  <= nx_cache && (nx_exc == MAT_EXC_NONE);
        rsp_onchip_q     <= nx_onchip && (nx_exc == MAT_EXC_NONE);
        rsp_exc_q        <= nx_exc;
        rsp_fault_addr_q <= (nx_exc == MAT_EXC_NONE) ? 32'h00000000 : acc_addr;
      end
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign rsp_valid      = rsp_valid_q;
  assign rsp_paddr      = rsp_paddr_q;
  assign rsp_cache_tag  = rsp_cache_tag_q;
  assign rsp_cacheable  = rsp_cacheable_q;
  assign rsp_onchip     = rsp_onchip_q;
  assign rsp_exc        = rsp_exc_q;
  assign rsp_fault_addr = rsp_fault_addr_q;

endmodule

// ==== dv/mat_top_assertions.sv ====
`timescale 1ns/1ps
module mat_chk (
  // Clock and reset.
  input logic              pclk,
  input logic              presetn,
  // Register port handshake.
  input logic              psel,
  input logic              penable,
  input logic              pready,
  // Core side.
  input logic              acc_valid,
  input logic [31:0]       acc_addr,
  input logic              privileged_mode_flag,
  input logic              signal_proc_extension_flag,
  input logic              rsp_valid,
  input logic [31:0]       rsp_paddr,
  input logic [31:0]       rsp_cache_tag,
  input logic              rsp_cacheable,
  input logic              rsp_onchip,
  input mat_pkg::mat_exc_t rsp_exc,
  input logic [31:0]       rsp_fault_addr
);
  import mat_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [2:0] top = acc_addr[31:29];
  wire       ap  = acc_valid & privileged_mode_flag;
  wire       au  = acc_valid & ~privileged_mode_flag;
  wire       ext = signal_proc_extension_flag;
  wire       xy  = acc_addr[31:24] == MAT_XY_TOP;
  property p_answer; acc_valid |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  property p_p1; ap && top == MAT_TOP_P1 |=> !rsp_exc && rsp_cacheable && rsp_paddr == {1'b0, $past(acc_addr[30:0])}; endproperty
  a_p1: assert property (p_p1) else $error("cached fixed region wrong");
  property p_p2; ap && top == MAT_TOP_P2 |=> !rsp_exc && !rsp_cacheable && rsp_paddr == {3'h0, $past(acc_addr[28:0])}; endproperty
  a_p2: assert property (p_p2) else $error("uncached fixed region wrong");
  property p_p4; ap && top == MAT_TOP_P4 |=> rsp_onchip; endproperty
  a_p4: assert property (p_p4) else $error("top region not on chip");
  property p_uerr; au && !ext && acc_addr[31] |=> rsp_exc == MAT_EXC_ADDR_ERR; endproperty
  a_uerr: assert property (p_uerr) else $error("user upper half not refused");
  property p_xy; au && ext && xy |=> !rsp_exc && !rsp_cacheable && rsp_paddr == $past(acc_addr); endproperty
  a_xy: assert property (p_xy) else $error("window access wrong");
  property p_xerr; au && ext && acc_addr[31] && !xy |=> rsp_exc == MAT_EXC_ADDR_ERR; endproperty
  a_xerr: assert property (p_xerr) else $error("user access outside window not refused");
  property p_tag; rsp_valid |-> rsp_cache_tag == {3'h0, rsp_paddr[28:0]}; endproperty
  a_tag: assert property (p_tag) else $error("cache tag top bits set");
  property p_fault; rsp_valid && rsp_exc != MAT_EXC_NONE |-> rsp_fault_addr == $past(acc_addr); endproperty
  a_fault: assert property (p_fault) else $error("fault address wrong");
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("ready not a single pulse");
  c_miss: cover property (rsp_valid && rsp_exc == MAT_EXC_MISS);
  c_aerr: cover property (rsp_valid && rsp_exc == MAT_EXC_ADDR_ERR);
  c_prot: cover property (rsp_valid && rsp_exc == MAT_EXC_PROT);
endmodule
bind mat_top mat_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .acc_valid(acc_valid), .acc_addr(acc_addr), .privileged_mode_flag(privileged_mode_flag),
  .signal_proc_extension_flag(signal_proc_extension_flag), .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr),
  .rsp_cache_tag(rsp_cache_tag), .rsp_cacheable(rsp_cacheable), .rsp_onchip(rsp_onchip), .rsp_exc(rsp_exc),
  .rsp_fault_addr(rsp_fault_addr));

// ==== dv/mat_core_model.sv ====
`timescale 1ns/1ps
module mat_core_model (
  // Clock.
  input wire logic pclk,
  // Access request.
  output logic        acc_valid,
  output logic [31:0] acc_addr,
  output logic        acc_write,
  output logic        privileged_mode_flag,
  output logic        signal_proc_extension_flag
);
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_write = 1'b0;
    privileged_mode_flag = 1'b1;
    signal_proc_extension_flag = 1'b0;
  end
  task automatic access(input logic [31:0] a, input logic w, p, e);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_write <= w;
    privileged_mode_flag <= p;
    signal_proc_extension_flag <= e;
    @(posedge pclk);
    acc_valid <= 1'b0;
    // The idle address is inverted so a stale value never looks like a request.
    acc_addr <= ~a;
    #1;
  endtask
endmodule

// ==== dv/mat_top_bench.sv ====
`timescale 1ns/1ps
module mat_top_bench;
  import mat_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd, rsp_paddr, rsp_cache_tag, rsp_fault_addr, acc_addr;
  logic        acc_valid, acc_write, priv, ext, rsp_valid, rsp_cacheable, rsp_onchip;
  mat_exc_t    rsp_exc;
  int          errors = 0, checks_done = 0, cyc = 0;
  logic [31:0] regs [5] = '{MAT_CTRL_ADDR, MAT_PEH_ADDR, MAT_PEL_ADDR, MAT_TBASE_ADDR, MAT_FAULT_ADDR};
  mat_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_write(acc_write), .privileged_mode_flag(priv), .signal_proc_extension_flag(ext),
    .rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr), .rsp_cache_tag(rsp_cache_tag), .rsp_cacheable(rsp_cacheable),
    .rsp_onchip(rsp_onchip), .rsp_exc(rsp_exc), .rsp_fault_addr(rsp_fault_addr));
  mat_core_model u_core (.pclk(pclk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .privileged_mode_flag(priv), .signal_proc_extension_flag(ext));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic load(input logic [31:0] h, l, input logic [1:0] way);
    apb(1'b1, MAT_PEH_ADDR, h);
    apb(1'b1, MAT_PEL_ADDR, l);
    apb(1'b1, MAT_LOAD_ADDR, {30'h0, way});
  endtask
  // Flags are write, privileged, extension.
  task automatic acc(input logic [31:0] a, input logic [2:0] f, input mat_exc_t x, input logic [31:0] pa,
    input logic c);
    u_core.access(a, f[2], f[1], f[0]);
    chk({31'h0, rsp_valid}, 32'h1);
    chk({29'h0, rsp_exc}, {29'h0, x});
    if (x == MAT_EXC_NONE) begin
      chk(rsp_paddr, pa);
      chk({31'h0, rsp_cacheable}, {31'h0, c});
      chk(rsp_cache_tag, {3'h0, pa[28:0]});
    end else chk(rsp_fault_addr, a);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      wrap_up;
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    apb(1'b0, 32'h0fffffe8, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, MAT_TBASE_ADDR, 32'ha5c30f1e);
    rdchk(MAT_TBASE_ADDR, 32'ha5c30f1e);
    apb(1'b1, MAT_CTRL_ADDR, 32'hffffffff);
    rdchk(MAT_CTRL_ADDR, MAT_CTL_MASK);
    apb(1'b1, MAT_CTRL_ADDR, 32'h0);
    acc(32'h8abc1234, 3'b010, MAT_EXC_NONE, 32'h0abc1234, 1'b1);
    acc(32'ha1234567, 3'b010, MAT_EXC_NONE, 32'h01234567, 1'b0);
    acc(32'hc0001000, 3'b010, MAT_EXC_NONE, 32'h00001000, 1'b1);
    acc(32'h6fff0000, 3'b000, MAT_EXC_NONE, 32'h0fff0000, 1'b1);
    u_core.access(32'he0000010, 1'b0, 1'b1, 1'b0);
    chk({31'h0, rsp_onchip}, 32'h1);
    acc(32'h80000000, 3'b000, MAT_EXC_ADDR_ERR, 32'h0, 1'b0);
    rdchk(MAT_FAULT_ADDR, 32'h80000000);
    acc(32'ha5000010, 3'b001, MAT_EXC_NONE, 32'ha5000010, 1'b0);
    acc(32'ha6000000, 3'b001, MAT_EXC_ADDR_ERR, 32'h0, 1'b0);
    apb(1'b1, MAT_CTRL_ADDR, 32'h1);
    acc(32'h00003123, 3'b010, MAT_EXC_MISS, 32'h0, 1'b0);
    acc(32'h80001000, 3'b010, MAT_EXC_NONE, 32'h00001000, 1'b1);
    load(32'h00003005, 32'h0001216c, 2'h0);
    acc(32'h00003123, 3'b010, MAT_EXC_NONE, 32'h00012123, 1'b1);
    acc(32'h00003123, 3'b100, MAT_EXC_NONE, 32'h00012123, 1'b1);
    acc(32'h00003523, 3'b010, MAT_EXC_MISS, 32'h0, 1'b0);
    apb(1'b1, MAT_PEH_ADDR, 32'h00003006);
    acc(32'h00003123, 3'b010, MAT_EXC_MISS, 32'h0, 1'b0);
    apb(1'b1, MAT_CTRL_ADDR, 32'h101);
    acc(32'h00003123, 3'b010, MAT_EXC_NONE, 32'h00012123, 1'b1);
    acc(32'h00003123, 3'b000, MAT_EXC_MISS, 32'h0, 1'b0);
    apb(1'b1, MAT_CTRL_ADDR, 32'h201);
    apb(1'b1, MAT_PEH_ADDR, 32'h00003005);
    acc(32'h00003123, 3'b010, MAT_EXC_MISS, 32'h0, 1'b0);
    load(32'h00003005, 32'h0001217c, 2'h1);
    acc(32'h00003523, 3'b010, MAT_EXC_NONE, 32'h00012523, 1'b1);
    load(32'h00003005, 32'h0001212c, 2'h1);
    acc(32'h00003123, 3'b000, MAT_EXC_PROT, 32'h0, 1'b0);
    load(32'h00003005, 32'h00012168, 2'h1);
    acc(32'h00003123, 3'b110, MAT_EXC_INIT_WRITE, 32'h0, 1'b0);
    wrap_up;
  end
endmodule
